// *** bench/rdf_peer.sv ***
// Model of the remote participant that takes frames and sends submessage fields.
`timescale 1ns/100ps
module rdf_peer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Octet stream from the controller
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  input wire logic stall,
  // Submessage fields towards the controller
  output logic rx_valid,
  output logic [7:0] rx_id,
  output logic [7:0] rx_flags,
  output logic rx_status_valid,
  output logic [7:0] rx_status
);
  logic [7:0] got[$];
  int frames = 0;

  // ****************************************
  // Octet sink
  // ****************************************
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_id = 8'h00;
    rx_flags = 8'h00;
    rx_status_valid = 1'b0;
    rx_status = 8'h00;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        if (tx_last) begin
          frames++;
        end
      end
    end
  end

  // ****************************************
  // Submessage sources
  // ****************************************
  // flags sent exactly as the scenario asks, so invalid combinations can be provoked.
  // Released fields show the inverse value so a stale octet is never mistaken for a fresh one.
  task automatic send_hdr(input logic [7:0] id, input logic [7:0] fl);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_flags <= fl;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_flags <= ~fl;
  endtask

  // status element only sent when not all zero
  task automatic send_status(input logic [7:0] st);
    @(posedge core_clk);
    rx_status_valid <= (st != 8'h00);
    rx_status <= st;
    @(posedge core_clk);
    rx_status_valid <= 1'b0;
    rx_status <= ~st;
  endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking testbench for the submessage flag framer controller.
`timescale 1ns/100ps
`include "rdf_defs.svh"
module testbench;
  import rdf_pkg::*;
  typedef struct {logic [7:0] ctrl; logic [15:0] len; logic [1:0] cmd; logic [7:0] fl; logic [15:0] oiq;} rdf_row_t;
  logic core_clk;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic irq;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_last;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] rx_id;
  logic [7:0] rx_flags;
  logic rx_status_valid;
  logic [7:0] rx_status;
  logic stall;
  logic [31:0] v;
  int mismatches;
  int checks;
  int base;
  logic [7:0] ra[6] = '{`RDF_REG_CTRL, `RDF_REG_LEN, `RDF_REG_STAT, `RDF_REG_IRQ_STAT, `RDF_REG_IRQ_EN, 8'h1c};
  rdf_row_t rows[8] = '{'{8'h00, 16'h0020, 2'h1, 8'h00, 16'h0010}, '{8'h01, 16'h1234, 2'h1, 8'h01, 16'h0010},
    '{8'h0a, 16'h0040, 2'h1, 8'h0a, 16'h0020}, '{8'h17, 16'h00a0, 2'h1, 8'h17, 16'h0014},
    '{8'h29, 16'hbeef, 2'h1, 8'h19, 16'h0024}, '{8'h4b, 16'h0100, 2'h1, 8'h03, 16'h0000},
    '{8'h30, 16'h0000, 2'h2, 8'h03, 16'h0000}, '{8'h11, 16'h0000, 2'h2, 8'h01, 16'h0000}};

  rdf_host #(.LEN_W(16)) uut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_id(rx_id), .rx_flags(rx_flags), .rx_status_valid(rx_status_valid),
    .rx_status(rx_status));
  rdf_peer peer (.core_clk(core_clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .stall(stall), .rx_valid(rx_valid), .rx_id(rx_id), .rx_flags(rx_flags),
    .rx_status_valid(rx_status_valid), .rx_status(rx_status));

  initial begin
    core_clk = 1'b0;
  end
  always #12.5 core_clk = ~core_clk;

  // ****************************************
  // Bus, compare and closing tasks
  // ****************************************
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic wait_frame(input int n);
    for (int t = 0; t < 200 && peer.frames != n; t++) begin
      @(posedge core_clk);
      #1;
    end
    if (peer.frames != n) begin
      mismatches++;
      final_report();
    end
  endtask

  task automatic run_row(input rdf_row_t r);
    logic [7:0] q[$];
    logic [15:0] ln;
    logic [15:0] oi;
    ln = r.ctrl[0] ? {r.len[7:0], r.len[15:8]} : r.len;
    oi = r.ctrl[0] ? {r.oiq[7:0], r.oiq[15:8]} : r.oiq;
    wr_reg(`RDF_REG_CTRL, {24'h0, r.ctrl});
    wr_reg(`RDF_REG_LEN, {16'h0, r.len});
    peer.got.delete();
    base = peer.frames + 1;
    wr_reg(`RDF_REG_CMD, {30'h0, r.cmd});
    wait_frame(base);
    if (r.cmd == 2'h2) q = '{8'h00, 8'h00, 8'h00, r.fl};
    else if (r.ctrl[6]) q = '{`RDF_ID_NOKEY_FRAG, r.fl, ln[15:8], ln[7:0]};
    else q = '{`RDF_ID_DATA, r.fl, ln[15:8], ln[7:0], 8'h00, 8'h00, oi[15:8], oi[7:0]};
    chk32(32'(peer.got.size()), 32'(q.size()));
    foreach (q[j]) chk8(peer.got[j], q[j]);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    stall = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (12) @(posedge core_clk);
    chk32({29'h0, tx_valid, tx_last, irq}, 32'h0);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      rd_reg(ra[i]);
      chk32(v, 32'h0);
    end
    wr_reg(`RDF_REG_CTRL, 32'hffffffff);
    rd_reg(`RDF_REG_CTRL);
    chk32(v, 32'h7f);
    wr_reg(`RDF_REG_LEN, 32'h12345678);
    rd_reg(`RDF_REG_LEN);
    chk32(v, 32'h5678);
    wr_reg(8'h1c, 32'hffffffff);
    rd_reg(8'h1c);
    chk32(v, 32'h0);
    wr_reg(`RDF_REG_IRQ_EN, 32'h1);
    foreach (rows[i]) run_row(rows[i]);
    chk32({31'h0, irq}, 32'h1);
    wr_reg(`RDF_REG_IRQ_CLR, 32'hf);
    repeat (2) @(posedge core_clk);
    #1;
    chk32({31'h0, irq}, 32'h0);
    // Refusals: data with key, empty status element; the masked event must not raise the line.
    peer.got.delete();
    wr_reg(`RDF_REG_CTRL, 32'h0c);
    wr_reg(`RDF_REG_CMD, 32'h1);
    rd_reg(`RDF_REG_IRQ_STAT);
    chk32(v, 32'h2);
    wr_reg(`RDF_REG_IRQ_CLR, 32'hf);
    wr_reg(`RDF_REG_CTRL, 32'h00);
    wr_reg(`RDF_REG_CMD, 32'h2);
    rd_reg(`RDF_REG_IRQ_STAT);
    chk32(v, 32'h2);
    chk32({31'h0, irq}, 32'h0);
    chk32(32'(peer.got.size()), 32'h0);
    wr_reg(`RDF_REG_IRQ_EN, 32'h2);
    repeat (2) @(posedge core_clk);
    #1;
    chk32({31'h0, irq}, 32'h1);
    wr_reg(`RDF_REG_IRQ_CLR, 32'hf);
    // A second command while the far side stalls is refused and the frame in flight stays whole.
    stall <= 1'b1;
    wr_reg(`RDF_REG_CTRL, 32'h02);
    base = peer.frames + 1;
    wr_reg(`RDF_REG_CMD, 32'h1);
    wr_reg(`RDF_REG_CMD, 32'h1);
    rd_reg(`RDF_REG_STAT);
    chk32(v & 32'h1, 32'h1);
    rd_reg(`RDF_REG_IRQ_STAT);
    chk32(v, 32'h2);
    stall <= 1'b0;
    wait_frame(base);
    chk32(32'(peer.got.size()), 32'h8);
    chk8(peer.got[1], 8'h02);
    // Receive decoding.
    wr_reg(`RDF_REG_IRQ_CLR, 32'hf);
    peer.send_hdr(`RDF_ID_DATA, 8'h0c);
    rd_reg(`RDF_REG_STAT);
    chk32(v & 32'h13e, 32'h118);
    rd_reg(`RDF_REG_IRQ_STAT);
    chk32(v, 32'hc);
    peer.send_hdr(`RDF_ID_DATA, 8'hf3);
    rd_reg(`RDF_REG_STAT);
    chk32(v & 32'h13e, 32'h026);
    peer.send_hdr(`RDF_ID_NOKEY_FRAG, 8'h1d);
    rd_reg(`RDF_REG_STAT);
    chk32(v & 32'h13e, 32'h002);
    peer.send_hdr(8'h07, 8'h0e);
    rd_reg(`RDF_REG_STAT);
    chk32(v & 32'h13e, 32'h002);
    peer.send_status(8'h01);
    rd_reg(`RDF_REG_STAT);
    chk32(v & 32'hc0, 32'h40);
    peer.send_status(8'hfe);
    rd_reg(`RDF_REG_STAT);
    chk32(v & 32'hc0, 32'h80);
    final_report();
  end
endmodule

// *** src/rdf_defs.svh ***
// Constants for the submessage flag framer controller.
`ifndef RDF_DEFS_SVH
`define RDF_DEFS_SVH

// ****************************************
// Submessage identifiers
// ****************************************
`define RDF_ID_DATA 8'h15
`define RDF_ID_NOKEY_FRAG 8'h11

// ****************************************
// Flag octet and status octet bit positions
// ****************************************
`define RDF_FLG_E 0
`define RDF_FLG_Q 1
`define RDF_FLG_D 2
`define RDF_FLG_K 3
`define RDF_FLG_I 4
`define RDF_FLG_X_LO 5
`define RDF_ST_DISP 0
`define RDF_ST_UNREG 1

// ****************************************
// Element sizes in octets
// ****************************************
`define RDF_SZ_FIXED 16'h0010
`define RDF_SZ_KEYHASH 16'h0010
`define RDF_SZ_STATUS 16'h0004
`define RDF_LEN_HDR_DATA 4'h8
`define RDF_LEN_HDR_FRAG 4'h4
`define RDF_LEN_STATUS 4'h4
`define RDF_IDX_EXTRA_LO 4'h4
`define RDF_IDX_EXTRA_HI 4'h5
`define RDF_IDX_FLAGS 4'h1

// ****************************************
// Register byte addresses
// ****************************************
`define RDF_REG_CTRL 8'h00
`define RDF_REG_LEN 8'h04
`define RDF_REG_CMD 8'h08
`define RDF_REG_STAT 8'h0c
`define RDF_REG_IRQ_STAT 8'h10
`define RDF_REG_IRQ_CLR 8'h14
`define RDF_REG_IRQ_EN 8'h18

// ****************************************
// Register fields
// ****************************************
`define RDF_CTRL_E 0
`define RDF_CTRL_Q 1
`define RDF_CTRL_D 2
`define RDF_CTRL_K 3
`define RDF_CTRL_DISP 4
`define RDF_CTRL_UNREG 5
`define RDF_CTRL_KIND 6
`define RDF_CTRL_W 7
`define RDF_CMD_HDR 0
`define RDF_CMD_STATUS 1
`define RDF_IRQ_W 4
`define RDF_IRQ_DONE 0
`define RDF_IRQ_REFUSED 1
`define RDF_IRQ_RX_BAD 2
`define RDF_IRQ_RX_FRAME 3
`define RDF_CTRL_RST 7'h00
`define RDF_IRQ_RST 4'h0

`endif

// *** src/rdf_flag_dec.sv ***
// Decoder for received submessage flag octets and status octets.
`timescale 1ns/100ps
`include "rdf_defs.svh"
module rdf_flag_dec
  import rdf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Received fields and decoded results
  rdf_rx_if.dec rx
);

  logic is_data;
  logic is_frag;
  logic dk_both;

  assign is_data = rx.valid && (rx.id == `RDF_ID_DATA);
  assign is_frag = rx.valid && (rx.id == `RDF_ID_NOKEY_FRAG);
  assign dk_both = rx.flags[`RDF_FLG_D] && rx.flags[`RDF_FLG_K];

  // ****************************************
  // Header flag decode
  // ****************************************
  // endianness bit.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx.endian <= 1'b0;
      rx.q <= 1'b0;
      rx.d <= 1'b0;
      rx.k <= 1'b0;
      rx.i <= 1'b0;
    end else if (is_data || is_frag) begin
      rx.endian <= rx.flags[`RDF_FLG_E];
      rx.q <= rx.flags[`RDF_FLG_Q];
      rx.d <= is_data && rx.flags[`RDF_FLG_D];
      rx.k <= is_data && rx.flags[`RDF_FLG_K];
      rx.i <= is_data && rx.flags[`RDF_FLG_I];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx.payload <= RDF_PL_NONE;
    end else if (is_data) begin
      unique case ({rx.flags[`RDF_FLG_D], rx.flags[`RDF_FLG_K]})
        2'b00: rx.payload <= RDF_PL_NONE;
        2'b10: rx.payload <= RDF_PL_DATA;
        2'b01: rx.payload <= RDF_PL_KEY;
        2'b11: rx.payload <= RDF_PL_BAD;
      endcase
    end else if (is_frag) begin
      rx.payload <= RDF_PL_NONE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx.bad <= 1'b0;
      rx.frame <= 1'b0;
    end else begin
      // verdict held for software.
      // It stands until the next Data frame, so a later fragment cannot hide it.
      if (is_data) begin
        rx.bad <= dk_both;
      end
      rx.frame <= is_data || is_frag;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx.disposed <= 1'b0;
      rx.unreg <= 1'b0;
    end else if (rx.st_valid) begin
      rx.disposed <= rx.st[`RDF_ST_DISP];
      rx.unreg <= rx.st[`RDF_ST_UNREG];
    end
  end

  property p_rx_bad;
    @(posedge core_clk) disable iff (!rst_n)
      (rx.valid && rx.id == `RDF_ID_DATA && rx.flags[`RDF_FLG_D] && rx.flags[`RDF_FLG_K])
      |=> (rx.bad && rx.payload == RDF_PL_BAD);
  endproperty
  a_rx_bad: assert property (p_rx_bad) else $error("Invalid data plus key not flagged.");

  property p_rx_status;
    @(posedge core_clk) disable iff (!rst_n)
      rx.st_valid |=> (rx.disposed == $past(rx.st[`RDF_ST_DISP]) && rx.unreg == $past(rx.st[`RDF_ST_UNREG]));
  endproperty
  a_rx_status: assert property (p_rx_status) else $error("Status octet decoded wrongly.");

  property p_rx_flags;
    @(posedge core_clk) disable iff (!rst_n)
      (rx.valid && rx.id == `RDF_ID_DATA)
      |=> (rx.q == $past(rx.flags[`RDF_FLG_Q]) && rx.d == $past(rx.flags[`RDF_FLG_D])
           && rx.k == $past(rx.flags[`RDF_FLG_K]) && rx.i == $past(rx.flags[`RDF_FLG_I]));
  endproperty
  a_rx_flags: assert property (p_rx_flags) else $error("Data flags decoded wrongly.");

endmodule

// *** src/rdf_host.sv ***
// Controller that frames submessage headers and status elements and decodes received flags.
`timescale 1ns/100ps
`include "rdf_defs.svh"

module rdf_host
  import rdf_pkg::*;
#(
  parameter int LEN_W = 16
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Interrupt
  output logic irq,
  // Transmit octet stream
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  // Received submessage fields
  input wire logic rx_valid,
  input wire logic [7:0] rx_id,
  input wire logic [7:0] rx_flags,
  input wire logic rx_status_valid,
  input wire logic [7:0] rx_status
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] fn_u16(input logic [15:0] v, input logic le);
    fn_u16 = le ? {v[7:0], v[15:8]} : v;
  endfunction

  function automatic logic [7:0] fn_flags(input logic [`RDF_CTRL_W-1:0] c);
    logic [7:0] f;
    f = 8'h00;
    f[`RDF_FLG_E] = c[`RDF_CTRL_E];
    f[`RDF_FLG_Q] = c[`RDF_CTRL_Q];
    if (!c[`RDF_CTRL_KIND]) begin
      f[`RDF_FLG_D] = c[`RDF_CTRL_D];
      f[`RDF_FLG_K] = c[`RDF_CTRL_K];
      f[`RDF_FLG_I] = c[`RDF_CTRL_DISP] | c[`RDF_CTRL_UNREG];
    end
    fn_flags = f;
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  rdf_state_t state_ff;
  logic [`RDF_CTRL_W-1:0] ctrl_ff;
  logic [LEN_W-1:0] len_ff;
  logic [`RDF_IRQ_W-1:0] irq_stat_ff;
  logic [`RDF_IRQ_W-1:0] irq_en_ff;
  logic [`RDF_IRQ_W-1:0] nxt_irq_stat;
  logic irq_ff;
  logic [31:0] rdata_ff;
  logic [63:0] sh_ff;
  logic [3:0] cnt_ff;
  logic [3:0] idx_ff;
  logic tx_valid_ff;
  logic tx_last_ff;
  logic [7:0] cur_flags_ff;
  logic cur_data_ff;
  logic cur_status_ff;
  logic [15:0] otiq_ff;
  logic st_any_ff;
  logic rx_dat_ff;

  logic go_hdr;
  logic go_st;
  logic ctrl_dk;
  logic ctrl_st_any;
  logic hdr_refuse;
  logic st_refuse;
  logic take;
  logic done_ev;
  logic [7:0] flags_now;
  logic [15:0] otiq_now;
  logic [15:0] len16;

  rdf_rx_if rxb ();

  assign go_hdr = wr && (addr == `RDF_REG_CMD) && wdata[`RDF_CMD_HDR];
  assign go_st = wr && (addr == `RDF_REG_CMD) && wdata[`RDF_CMD_STATUS] && !wdata[`RDF_CMD_HDR];
  assign ctrl_dk = ctrl_ff[`RDF_CTRL_D] && ctrl_ff[`RDF_CTRL_K] && !ctrl_ff[`RDF_CTRL_KIND];
  assign ctrl_st_any = ctrl_ff[`RDF_CTRL_DISP] || ctrl_ff[`RDF_CTRL_UNREG];
  assign flags_now = fn_flags(ctrl_ff);
  assign len16 = 16'(len_ff);
  assign take = tx_valid_ff && tx_ready;
  assign done_ev = take && (cnt_ff == 4'h1);

  // refuse a header with both data and key.
  assign hdr_refuse = go_hdr && ((state_ff != RDF_IDLE) || ctrl_dk);
  // status element refused when all its bits are clear.
  assign st_refuse = go_st && ((state_ff != RDF_IDLE) || !ctrl_st_any || ctrl_ff[`RDF_CTRL_KIND]);

  // offset grows only by the elements present.
  assign otiq_now = `RDF_SZ_FIXED + (ctrl_ff[`RDF_CTRL_K] ? `RDF_SZ_KEYHASH : 16'h0000)
                  + (ctrl_st_any ? `RDF_SZ_STATUS : 16'h0000);

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `RDF_CTRL_RST;
      len_ff <= '0;
      irq_en_ff <= `RDF_IRQ_RST;
    end else if (wr) begin
      if (addr == `RDF_REG_CTRL) begin
        ctrl_ff <= wdata[`RDF_CTRL_W-1:0];
      end
      if (addr == `RDF_REG_LEN) begin
        len_ff <= wdata[LEN_W-1:0];
      end
      if (addr == `RDF_REG_IRQ_EN) begin
        irq_en_ff <= wdata[`RDF_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        `RDF_REG_CTRL: rdata_ff <= 32'(ctrl_ff);
        `RDF_REG_LEN: rdata_ff <= 32'(len_ff);
        `RDF_REG_STAT: rdata_ff <= {23'h0, rxb.bad, rxb.unreg, rxb.disposed, rxb.i, rxb.k,
                                    rxb.d, rxb.q, rxb.endian, (state_ff != RDF_IDLE)};
        `RDF_REG_IRQ_STAT: rdata_ff <= 32'(irq_stat_ff);
        `RDF_REG_IRQ_EN: rdata_ff <= 32'(irq_en_ff);
        default: rdata_ff <= 32'h0;
      endcase
    end else begin
      rdata_ff <= 32'h0;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // A new event wins over a clear in the same cycle.
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr && (addr == `RDF_REG_IRQ_CLR)) begin
      nxt_irq_stat = irq_stat_ff & ~wdata[`RDF_IRQ_W-1:0];
    end
    if (done_ev) begin
      nxt_irq_stat[`RDF_IRQ_DONE] = 1'b1;
    end
    if (hdr_refuse || st_refuse) begin
      nxt_irq_stat[`RDF_IRQ_REFUSED] = 1'b1;
    end
    // received invalid combination raises an event.
    if (rxb.bad && rx_dat_ff) begin
      nxt_irq_stat[`RDF_IRQ_RX_BAD] = 1'b1;
    end
    if (rxb.frame) begin
      nxt_irq_stat[`RDF_IRQ_RX_FRAME] = 1'b1;
    end
  end

  // The decoded verdict is held, so the event fires only once, right after a Data frame.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_dat_ff <= 1'b0;
    end else begin
      rx_dat_ff <= rx_valid && (rx_id == `RDF_ID_DATA);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= `RDF_IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  // ****************************************
  // Transmit framer
  // ****************************************
  // Octets leave most significant first from one shift register, so the
  // framer needs no byte multiplexer; the price is 64 flip-flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= RDF_IDLE;
      sh_ff <= 64'h0;
      cnt_ff <= 4'h0;
      idx_ff <= 4'h0;
      tx_valid_ff <= 1'b0;
      tx_last_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        RDF_IDLE: begin
          if (go_hdr && !hdr_refuse) begin
            state_ff <= RDF_SEND;
            tx_valid_ff <= 1'b1;
            idx_ff <= 4'h0;
            // multi-octet fields follow the endian bit.
            if (!ctrl_ff[`RDF_CTRL_KIND]) begin
              sh_ff <= {`RDF_ID_DATA, flags_now, fn_u16(len16, ctrl_ff[`RDF_CTRL_E]), 16'h0,
                        fn_u16(otiq_now, ctrl_ff[`RDF_CTRL_E])};
              cnt_ff <= `RDF_LEN_HDR_DATA;
            end else begin
              sh_ff <= {`RDF_ID_NOKEY_FRAG, flags_now, fn_u16(len16, ctrl_ff[`RDF_CTRL_E]), 32'h0};
              cnt_ff <= `RDF_LEN_HDR_FRAG;
            end
          end else if (go_st && !st_refuse) begin
            state_ff <= RDF_SEND;
            tx_valid_ff <= 1'b1;
            idx_ff <= 4'h0;
            // disposed bit placed in the status octet.
            // unregistered bit placed in the status octet.
            sh_ff <= {24'h0, 6'h0, ctrl_ff[`RDF_CTRL_UNREG], ctrl_ff[`RDF_CTRL_DISP], 32'h0};
            cnt_ff <= `RDF_LEN_STATUS;
          end
        end
        RDF_SEND: begin
          if (take) begin
            sh_ff <= {sh_ff[55:0], 8'h00};
            cnt_ff <= cnt_ff - 4'h1;
            idx_ff <= idx_ff + 4'h1;
            tx_last_ff <= (cnt_ff == 4'h2);
            if (cnt_ff == 4'h1) begin
              state_ff <= RDF_IDLE;
              tx_valid_ff <= 1'b0;
              tx_last_ff <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Shadow of what the current frame was built from.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_flags_ff <= 8'h00;
      cur_data_ff <= 1'b0;
      cur_status_ff <= 1'b0;
      otiq_ff <= 16'h0;
      st_any_ff <= 1'b0;
    end else if (state_ff == RDF_IDLE && ((go_hdr && !hdr_refuse) || (go_st && !st_refuse))) begin
      cur_flags_ff <= flags_now;
      cur_data_ff <= go_hdr && !ctrl_ff[`RDF_CTRL_KIND];
      cur_status_ff <= !go_hdr;
      otiq_ff <= otiq_now;
      st_any_ff <= ctrl_st_any;
    end
  end

  // ****************************************
  // Receive decoder
  // ****************************************
  assign rxb.valid = rx_valid;
  assign rxb.id = rx_id;
  assign rxb.flags = rx_flags;
  assign rxb.st_valid = rx_status_valid;
  assign rxb.st = rx_status;

  rdf_flag_dec u_dec (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rx(rxb.dec)
  );

  assign rdata = rdata_ff;
  assign irq = irq_ff;
  assign tx_data = sh_ff[63:56];
  assign tx_valid = tx_valid_ff;
  assign tx_last = tx_last_ff;

  // ****************************************
  // Checks
  // ****************************************
  property p_no_dk;
    @(posedge core_clk) disable iff (!rst_n)
      tx_valid_ff |-> !(cur_flags_ff[`RDF_FLG_D] && cur_flags_ff[`RDF_FLG_K]);
  endproperty
  a_no_dk: assert property (p_no_dk) else $error("Data and key sent together.");

  property p_refuse;
    @(posedge core_clk) disable iff (!rst_n)
      (go_hdr && state_ff == RDF_IDLE && ctrl_dk) |=> (state_ff == RDF_IDLE && irq_stat_ff[`RDF_IRQ_REFUSED]);
  endproperty
  a_refuse: assert property (p_refuse) else $error("Invalid header not refused.");

  property p_x_clear;
    @(posedge core_clk) disable iff (!rst_n)
      tx_valid_ff |-> (cur_flags_ff[7:`RDF_FLG_X_LO] == 3'h0);
  endproperty
  a_x_clear: assert property (p_x_clear) else $error("Unused flag bits set.");

  property p_frag_flags;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_valid_ff && !cur_data_ff && !cur_status_ff) |-> (cur_flags_ff[7:`RDF_FLG_D] == 6'h00);
  endproperty
  a_frag_flags: assert property (p_frag_flags) else $error("Fragment header has extra flags.");

  property p_extra_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_valid_ff && cur_data_ff && (idx_ff == `RDF_IDX_EXTRA_LO || idx_ff == `RDF_IDX_EXTRA_HI))
      |-> (tx_data == 8'h00);
  endproperty
  a_extra_zero: assert property (p_extra_zero) else $error("Extra flags not zero.");

  property p_status_flag;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_valid_ff && cur_data_ff) |-> (cur_flags_ff[`RDF_FLG_I] == st_any_ff);
  endproperty
  a_status_flag: assert property (p_status_flag) else $error("Status flag disagrees with status bits.");

  property p_flag_octet;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_valid_ff && !cur_status_ff && idx_ff == `RDF_IDX_FLAGS) |-> (tx_data == cur_flags_ff);
  endproperty
  a_flag_octet: assert property (p_flag_octet) else $error("Flag octet wrong on the wire.");

  property p_otiq;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_valid_ff && cur_data_ff) |-> (otiq_ff == `RDF_SZ_FIXED
        + (cur_flags_ff[`RDF_FLG_K] ? `RDF_SZ_KEYHASH : 16'h0000)
        + (cur_flags_ff[`RDF_FLG_I] ? `RDF_SZ_STATUS : 16'h0000));
  endproperty
  a_otiq: assert property (p_otiq) else $error("Inline QoS offset wrong.");

  property p_done;
    @(posedge core_clk) disable iff (!rst_n)
      (take && tx_last_ff) |=> (!tx_valid_ff && irq_stat_ff[`RDF_IRQ_DONE]);
  endproperty
  a_done: assert property (p_done) else $error("Frame end not reported.");

endmodule

// *** src/rdf_pkg.sv ***
// Types shared by the submessage flag framer controller.
package rdf_pkg;
  typedef enum {RDF_IDLE, RDF_SEND} rdf_state_t;
  typedef enum logic [1:0] {RDF_PL_NONE, RDF_PL_DATA, RDF_PL_KEY, RDF_PL_BAD} rdf_payload_t;
endpackage

// *** src/rdf_rx_if.sv ***
// Carrier between the controller and its receive flag decoder.
`timescale 1ns/100ps
interface rdf_rx_if;
  import rdf_pkg::*;
  logic valid;
  logic [7:0] id;
  logic [7:0] flags;
  logic st_valid;
  logic [7:0] st;
  logic endian;
  logic q;
  logic d;
  logic k;
  logic i;
  logic disposed;
  logic unreg;
  rdf_payload_t payload;
  logic bad;
  logic frame;
  modport dec (input valid, id, flags, st_valid, st,
               output endian, q, d, k, i, disposed, unreg, payload, bad, frame);
  modport mon (output valid, id, flags, st_valid, st,
               input endian, q, d, k, i, disposed, unreg, payload, bad, frame);
endinterface
